// *** common/rx_page_defs.vh ***
// Offsets, field positions and reset values for the receive port paging block.
// Included by the paging register bank; definitions only.
`ifndef RX_PAGE_DEFS_VH
`define RX_PAGE_DEFS_VH
`define OFF_RESERVED_A 8'h48
`define OFF_RESERVED_B 8'h49
`define OFF_LINK_CAP 8'h4a
`define OFF_EMBED_TYPE 8'h4b
`define OFF_PAGE_SELECT 8'h4c
`define PAGE_LO_START 8'h4d
`define PAGE_LO_END 8'h7f
`define PAGE_HI_START 8'hd0
`define PAGE_HI_END 8'hdf
`define CAP_CRC_FLAG_BIT 4
`define CAP_RESET 1'b0
`define EMBED_COUNT_MSB 7
`define EMBED_COUNT_LSB 6
`define EMBED_VALUE_MSB 5
`define EMBED_VALUE_LSB 0
`define EMBED_RESET 8'h12
`define SEL_PHYS_MSB 7
`define SEL_PHYS_LSB 6
`define SEL_READ_MSB 5
`define SEL_READ_LSB 4
`define SEL_WRITE_MSB 3
`define SEL_WRITE_LSB 0
`define NUM_SOURCES 5
`define SRC_LOCAL 3'h0
`endif

// *** hw/rx_port_register_paging.v ***
// Paged register bank for a four-port receive hub: page select, capability
// and embedded line type registers, with per-source page control.
// Assumes one single-cycle access port shared by all sources, a source id
// (0 local, 1..4 back channel of port 0..3), and an external paged store.
// Source ids 5 to 7 are never presented; the access arbiter filters them.
// Frame and packet strobes come from receiver logic on the same clock.
// Notes on behaviour
// - Paged ranges follow port selection, not shared
// - Read field picks one of four ports
// - Write enables broadcast one write to many
// - Physical field: zero locally, port remotely
// - Read select defaults to source port
// - Only own port write enable defaults set remotely; none locally
// - Separate page select copy per source
// - Selection governs capability and embedded type
// - Embedded count picks first N packets embedded
// - First N lines carry programmed embedded type
// - Override ignored for formatted receiver input
`timescale 1ns/1ps
`include "rx_page_defs.vh"
module rx_port_register_paging (
  input wire sys_clk,
  input wire rst_n,
  input wire regWrite,
  input wire regRead,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire [2:0] regSource,
  input wire [7:0] pagedRdData,
  input wire [3:0] formattedInput,
  input wire [3:0] frameStart,
  input wire [3:0] longPacket,
  input wire [23:0] rawTypeIn,
  output reg [7:0] regRdData,
  output reg regRdValid,
  output reg pagedWrite,
  output reg pagedRead,
  output reg [3:0] pagedWrEnable,
  output reg [1:0] pagedRdPort,
  output reg [7:0] pagedAddr,
  output reg [7:0] pagedWrData,
  output reg [3:0] crcFlagEnable,
  output reg [23:0] lineTypeOut
);

  // Page control: one read port and one set of write enables per source,
  // so a remote host paging through its own port never moves the local
  // host's page and the other way round
  reg [1:0] readSel_q [0:4];
  reg [3:0] writeSel_q [0:4];
  // Per-port register copies; only bit 4 of the capability register exists
  reg [3:0] cap_q;
  reg [7:0] embed_q [0:3];
  // Long packets seen since frame start, saturating at three
  reg [1:0] lineCount_q [0:3];
  // Selection of the source that makes the current access
  wire [1:0] curRead;
  wire [3:0] curWrite;
  wire [1:0] physNum;
  wire inPage;
  reg [7:0] rdMux;

  // Look up the page control copy of the accessing source
  assign curRead = readSel_q[regSource];
  assign curWrite = writeSel_q[regSource];
  // Physical number: zero for local host, port number over the back channel
  assign physNum = (regSource == `SRC_LOCAL) ? 2'h0 : regSource[1:0] - 2'h1;
  // Paged ranges live in the external store; everything else is local here.
  // The page select register itself is shared space and is never paged.
  assign inPage = ((regAddr >= `PAGE_LO_START) && (regAddr <= `PAGE_LO_END))
    || ((regAddr >= `PAGE_HI_START) && (regAddr <= `PAGE_HI_END));

  // Per-source select copies with source-dependent defaults.
  // Source 0 is the local host and starts with port 0 read, no writes;
  // a back channel source starts paged onto its own port, write enabled.
  // Only the source that writes the page select register updates its copy.
  genvar s;
  generate
    for (s = 0; s < `NUM_SOURCES; s = s + 1)
    begin : gSrc
      // Receive port that this source arrives over, zero for the local host
      localparam [31:0] PORT_IDX = (s == 0) ? 0 : s - 1;
      localparam [1:0] READ_DEFAULT = PORT_IDX[1:0];
      localparam [3:0] WRITE_DEFAULT = (s == 0) ? 4'h0 : (4'h1 << PORT_IDX[1:0]);

      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          readSel_q[s] <= READ_DEFAULT;
          writeSel_q[s] <= WRITE_DEFAULT;
        end
        else if (regWrite && regAddr == `OFF_PAGE_SELECT && regSource == s)
        begin
          readSel_q[s] <= regWrData[`SEL_READ_MSB:`SEL_READ_LSB];
          writeSel_q[s] <= regWrData[`SEL_WRITE_MSB:`SEL_WRITE_LSB];
        end
      end
    end
  endgenerate

  // Per-port paged registers, written in unison for every enabled port.
  // A write with no enable set falls through and leaves every copy alone.
  // Reserved capability bits are not stored, so they read back as zero.
  genvar p;
  generate
    for (p = 0; p < 4; p = p + 1)
    begin : gPort
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          cap_q[p] <= `CAP_RESET;
          embed_q[p] <= `EMBED_RESET;
        end
        else if (regWrite && curWrite[p])
        begin
          if (regAddr == `OFF_LINK_CAP)
            cap_q[p] <= regWrData[`CAP_CRC_FLAG_BIT];
          if (regAddr == `OFF_EMBED_TYPE)
            embed_q[p] <= regWrData;
        end
      end

      // Line counter per frame and data type override.
      // The counter clears on frame start and counts long packets, so the
      // first N lines of a frame see a count below the programmed N.
      // Formatted input always passes the raw type from rawTypeIn untouched.
      // Frame start itself shows the raw type; the count is stale then.
      always @(posedge sys_clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          lineCount_q[p] <= 2'h0;
          lineTypeOut[p*6 +: 6] <= 6'h00;
        end
        else
        begin
          if (frameStart[p])
            lineCount_q[p] <= 2'h0;
          else if (longPacket[p] && lineCount_q[p] != 2'h3)
            lineCount_q[p] <= lineCount_q[p] + 2'h1;
          if (!formattedInput[p]
            && lineCount_q[p] < embed_q[p][`EMBED_COUNT_MSB:`EMBED_COUNT_LSB]
            && !frameStart[p])
            lineTypeOut[p*6 +: 6] <= embed_q[p][`EMBED_VALUE_MSB:`EMBED_VALUE_LSB];
          else
            lineTypeOut[p*6 +: 6] <= rawTypeIn[p*6 +: 6];
        end
      end
    end
  endgenerate

  // Readback mux; reserved space reads zero.
  // Paged reads take the external store's data, which the store must
  // present for the reading source's selected port in the same cycle.
  always @*
  begin
    case (regAddr)
      `OFF_LINK_CAP: rdMux = {3'h0, cap_q[curRead], 4'h0};
      `OFF_EMBED_TYPE: rdMux = embed_q[curRead];
      `OFF_PAGE_SELECT: rdMux = {physNum, curRead, curWrite};
      default: rdMux = inPage ? pagedRdData : 8'h00;
    endcase
  end

  // Registered outputs.
  // Every strobe lasts one cycle; read data is zero when no read answers.
  // A paged write with no port enabled is dropped before the store.
  always @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData <= 8'h00;
      regRdValid <= 1'b0;
      pagedWrite <= 1'b0;
      pagedRead <= 1'b0;
      pagedWrEnable <= 4'h0;
      pagedRdPort <= 2'h0;
      pagedAddr <= 8'h00;
      pagedWrData <= 8'h00;
      crcFlagEnable <= 4'h0;
    end
    else
    begin
      regRdData <= regRead ? rdMux : 8'h00;
      regRdValid <= regRead;
      pagedWrite <= regWrite && inPage && (curWrite != 4'h0);
      pagedRead <= regRead && inPage;
      pagedWrEnable <= curWrite;
      pagedRdPort <= curRead;
      pagedAddr <= regAddr;
      pagedWrData <= regWrData;
      crcFlagEnable <= cap_q;
    end
  end

endmodule

// *** bench/paging_checker.sv ***
// Port checker for the paging register bank.
// Assumes single-cycle strobes on sys_clk.
`timescale 1ns/1ps
module paging_checker(
  input sys_clk,
  input rst_n,
  input regRead,
  input regWrite,
  input [7:0] regAddr,
  input [7:0] regRdData,
  input regRdValid,
  input pagedRead,
  input pagedWrite,
  input [3:0] pagedWrEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_read_answer:
    assert property (regRead |=> regRdValid) else $error("read not answered");
  a_idle_zero:
    assert property (!regRead |=> !regRdValid && regRdData == 8'h00) else $error("stray data");
  a_rsvd_zero:
    assert property (regRead && regAddr[7:1] == 7'h24 |=> regRdData == 8'h00) else $error("rsvd");
  a_cap_fields:
    assert property (regRead && regAddr == 8'h4a |=> !(regRdData & 8'hef)) else $error("cap");
  a_page_read:
    assert property (regRead && regAddr inside {[8'h4d:8'h7f], [8'hd0:8'hdf]} |=> pagedRead)
      else $error("paged read lost");
  a_write_cause:
    assert property (pagedWrite |-> $past(regWrite) && pagedWrEnable != 4'h0) else $error("pw");
  a_local_write:
    assert property (regWrite && regAddr < 8'h4d |=> !pagedWrite) else $error("local paged");
  a_read_cause:
    assert property (pagedRead |-> $past(regRead)) else $error("stray paged read");
endmodule

// *** bench/paged_store.sv ***
// Four-copy paged register store beside the bank.
// Read port is chosen by the bench.
`timescale 1ns/1ps
module paged_store(
  input sys_clk,
  input pagedWrite,
  input [3:0] pagedWrEnable,
  input [7:0] pagedAddr,
  input [7:0] pagedWrData,
  input [7:0] regAddr,
  input [1:0] rdPort,
  output [7:0] pagedRdData
);
  logic [7:0] m[4][256];
  // Broadcast write into every enabled copy
  always @(posedge sys_clk)
    for (int p = 0; p < 4; p++)
      if (pagedWrite && pagedWrEnable[p]) m[p][pagedAddr] <= pagedWrData;
  assign pagedRdData = m[rdPort][regAddr];
endmodule

// *** bench/tb_top.sv ***
// Bench for the paging bank with its paged store.
// Drives 1 ns after each rising edge.
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 0, rst_n = 0, regWrite = 0, regRead = 0;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData, pagedRdData, pagedAddr, pagedWrData;
  logic [2:0] regSource = 0;
  logic [3:0] formattedInput = 4'h2, frameStart = 0, longPacket = 0, crcFlagEnable;
  logic [3:0] pagedWrEnable;
  logic [23:0] rawTypeIn = {4{6'h2b}}, lineTypeOut;
  logic [1:0] rp = 0, pagedRdPort;
  logic regRdValid, pagedWrite, pagedRead;
  int errors = 0, comparisons = 0;
  always #2 sys_clk = ~sys_clk;
  rx_port_register_paging i_rx_port_register_paging(.*);
  paged_store i_paged_store(.rdPort(rp), .*);
  task chk(input [7:0] g, input [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // One access; reads are checked when the answer stands
  task acc(input [2:0] s, input w, input [7:0] a, input [7:0] d, input [7:0] e);
    @(posedge sys_clk) #1;
    {regSource, regWrite, regRead, regAddr, regWrData} = {s, w, !w, a, d};
    @(posedge sys_clk) #1;
    {regWrite, regRead} = 2'b00;
    if (!w) chk(regRdData, e);
  endtask
  task tick(input [3:0] f, input [3:0] l);
    @(posedge sys_clk) #1;
    {frameStart, longPacket} = {f, l};
    @(posedge sys_clk) #1;
    {frameStart, longPacket} = 8'h00;
    @(posedge sys_clk) #1;
  endtask
  task end_of_test;
    if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #20000;
    errors++;
    end_of_test;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1;
    acc(0, 0, 8'h4c, 0, 8'h00);
    acc(3, 0, 8'h4c, 0, 8'ha4);
    acc(0, 1, 8'h4a, 8'hff, 0);
    acc(0, 0, 8'h4a, 0, 8'h00);
    acc(0, 1, 8'h48, 8'hff, 0);
    acc(0, 0, 8'h48, 0, 8'h00);
    acc(0, 0, 8'h4b, 0, 8'h12);
    acc(0, 1, 8'h4c, 8'hfa, 0);
    acc(0, 0, 8'h4c, 0, 8'h3a);
    acc(0, 1, 8'h4a, 8'hff, 0);
    acc(0, 0, 8'h4a, 0, 8'h10);
    chk({4'h0, crcFlagEnable}, 8'h0a);
    acc(0, 1, 8'h4c, 8'h00, 0);
    acc(0, 0, 8'h4a, 0, 8'h00);
    acc(1, 0, 8'h4c, 0, 8'h01);
    acc(0, 1, 8'h4c, 8'h02, 0);
    acc(0, 1, 8'h50, 8'ha5, 0);
    chk(pagedAddr, 8'h50);
    chk(pagedWrData, 8'ha5);
    chk({4'h0, pagedWrEnable}, 8'h02);
    rp = 1;
    acc(0, 1, 8'h4c, 8'h10, 0);
    acc(0, 0, 8'h50, 0, 8'ha5);
    chk({6'h00, pagedRdPort}, 8'h01);
    acc(0, 1, 8'h4c, 8'h0f, 0);
    acc(0, 1, 8'h4b, 8'h45, 0);
    tick(4'hf, 0);
    chk(lineTypeOut[5:0], 8'h05);
    chk(lineTypeOut[11:6], 8'h2b);
    tick(0, 4'hf);
    chk(lineTypeOut[5:0], 8'h2b);
    acc(0, 1, 8'h4b, 8'hc7, 0);
    tick(4'h1, 0);
    chk(lineTypeOut[5:0], 8'h07);
    tick(0, 4'h1);
    chk(lineTypeOut[5:0], 8'h07);
    tick(0, 4'h1);
    chk(lineTypeOut[5:0], 8'h07);
    tick(0, 4'h1);
    chk(lineTypeOut[5:0], 8'h2b);
    end_of_test;
  end
endmodule
bind rx_port_register_paging paging_checker i_paging_checker(.*);
